// >>> cbf_pkg.sv
// Purpose: constants and types for the CAN buffer and filter registers
// Assumes: APB slave, 32-bit data, byte registers in the low lanes
// Notes: one word per register
package cbf_pkg;
  // Address map
  localparam int ADDR_W = 12;
  localparam logic [11:0] BUF_BASE = 12'h000;
  localparam logic [11:0] DIR_ADDR = 12'h180;
  localparam logic [11:0] MODE_ADDR = 12'h184;
  localparam logic [11:0] FILT_BASE = 12'h200;
  localparam logic [11:0] MASK_BASE = 12'h400;
  localparam logic [3:0] LEN_IDX = 4'h8;
  localparam logic [2:0] PTR_IDX = 3'h4;
  // Counts
  localparam int NBUF = 6;
  localparam int NBYTE = 8;
  localparam int NFILT = 16;
  localparam int NLEGACY = 6;
  localparam int NMASK = 2;
  // Field positions
  localparam int RTR_BIT = 6;
  localparam int EXT_BIT = 3;
  localparam logic [7:0] SIDL_IMPL = 8'hEB;
  localparam logic [7:0] DIR_IMPL = 8'hFC;
  localparam logic [3:0] DLC_MAX = 4'h8;
  localparam logic [3:0] PTR_FIRST_BUF = 4'h2;
  localparam logic [3:0] PTR_LAST_BUF = 4'h7;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_DIR = 6'h00;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  // Frame handed over by the protocol engine
  typedef struct packed {
    logic [28:0] id;
    logic ext;
    logic rtr;
    logic [3:0] length_code;
    logic [63:0] data;
  } cbf_frame_t;
  // Result of acceptance filtering
  typedef struct packed {
    logic hit;
    logic [3:0] filter;
    logic [3:0] dest;
  } cbf_accept_t;
endpackage

// >>> cbf_regs.sv
// Purpose: buffer, direction, filter and mask registers with acceptance logic
// Assumes: engine supplies frames on mclk and reports busy transmit buffers
// Notes: zero-wait APB, read data captured in the setup cycle
//
// What this block does
// - Direction bits 7..2 pick transmit (1) or receive (0); bits 1..0 read zero
// - Receiving buffer exposes eight data bytes, readable only
// - Transmitting buffer exposes eight data bytes, readable and writable
// - Length code 0 to 8 gives byte count; 9 to 15 load all eight bytes
// - Receiving buffer length bit 6 shows remote request, not writable
// - Receiving buffer length bits 7, 5, 4 read zero
// - Transmitting buffer length bit 6 sets the outgoing remote bit
// - Transmitting buffer length bits 7, 5, 4 read zero; bits 3..0 writable
// - Buffer data and length registers exist only in enhanced modes
// - Filter high byte and low bits 7..5 hold identifier bits 28..18
// - Extended bits 17..16, 15..8 and 7..0 sit in low, ext high, ext low
// - Filter low bit 3 selects extended-only or standard-only frames
// - Filters 6 to 15 exist only in enhanced modes
// - Two masks hold identifier mask bits in the same four-byte layout as the filters
// - Busy transmitting buffer registers are read-only to software
// - Filter pointer bits 3..0 select dedicated or configurable destination; bit 4 picks the mask
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module cbf_regs
  import cbf_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive side of the protocol engine
  input wire logic rx_valid,
  input wire cbf_frame_t rx_frame,
  output cbf_accept_t rx_accept,
  // Transmit side of the protocol engine
  input wire logic [NBUF-1:0] tx_busy,
  output logic [NBUF-1:0] tx_dir,
  output logic [NBUF-1:0] tx_rtr,
  output logic [NBUF*4-1:0] tx_dlc,
  output logic [NBUF*64-1:0] tx_data,
  output logic enhanced
);
  logic [7:0] data_reg [NBUF][NBYTE];
  logic [4:0] len_reg [NBUF];
  logic [5:0] dir_reg;
  logic [1:0] mode_reg;
  logic [7:0] filt_reg [NFILT][4];
  logic [4:0] fptr_reg [NFILT];
  logic [7:0] mask_reg [NMASK][4];
  logic [31:0] rdata_reg;
  logic err_reg;
  cbf_accept_t acc_reg;
  cbf_accept_t acc_next;

  // Address map, one byte register per aligned word:
  //   buffer n byte m at 0x40*n + 4*m, buffer n length at 0x40*n + 0x20
  //   direction at 0x180, mode at 0x184 (any nonzero mode is enhanced)
  //   filter f register k at 0x200 + 0x20*f + 4*k, k = 4 is the pointer
  //   mask n register k at 0x400 + 0x10*n + 4*k
  // Holes answer with an error; writes into them are dropped
  // Address decode
  logic is_buf, is_dir, is_mode, is_filt, is_mask, is_len, okay;
  logic [2:0] bn;
  logic [3:0] bm;
  logic [3:0] fn;
  logic [2:0] fk;
  logic mn;
  logic [1:0] mk;
  logic setup, access, wr;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign enhanced = (mode_reg != MODE_LEGACY);
  assign bn = paddr[8:6];
  assign bm = paddr[5:2];
  assign fn = paddr[8:5];
  assign fk = paddr[4:2];
  assign mn = paddr[4];
  assign mk = paddr[3:2];
  assign is_len = (bm == LEN_IDX);

  // Region checks; buffers and upper filters vanish in legacy mode
  always_comb begin
    is_buf = (paddr[11:9] == BUF_BASE[11:9]) && (bn < NBUF) && (bm <= LEN_IDX)
      && (paddr[1:0] == 2'h0) && enhanced;
    is_dir = (paddr == DIR_ADDR);
    is_mode = (paddr == MODE_ADDR);
    is_filt = (paddr[11:9] == FILT_BASE[11:9]) && (fk <= PTR_IDX)
      && (paddr[1:0] == 2'h0) && (enhanced || fn < NLEGACY);
    is_mask = (paddr[11:5] == MASK_BASE[11:5]) && (paddr[1:0] == 2'h0);
    okay = is_buf | is_dir | is_mode | is_filt | is_mask;
  end

  // Read value of the addressed register
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (is_buf && is_len) begin
      rd_byte = {1'b0, len_reg[bn][4], 2'b00, len_reg[bn][3:0]};
    end else if (is_buf) begin
      rd_byte = data_reg[bn][bm[2:0]];
    end else if (is_dir) begin
      rd_byte = {dir_reg, 2'b00};
    end else if (is_mode) begin
      rd_byte = {6'h00, mode_reg};
    end else if (is_filt && fk == PTR_IDX) begin
      rd_byte = {3'h0, fptr_reg[fn]};
    end else if (is_filt) begin
      rd_byte = filt_reg[fn][fk[1:0]];
    end else if (is_mask) begin
      rd_byte = mask_reg[mn][mk];
    end
  end

  // Answer captured in setup so read data comes from flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (setup) begin
      rdata_reg <= {24'h00_0000, rd_byte};
      err_reg <= ~okay;
    end
  end

  // Zero wait states: every access cycle completes
  assign prdata = rdata_reg;
  assign pslverr = err_reg & access;
  assign pready = access;

  // Software may write a buffer only as transmitter and while idle
  logic buf_wr;
  assign buf_wr = wr & is_buf & dir_reg[bn] & ~tx_busy[bn];

  // Acceptance filtering, lowest numbered filter wins
  logic [NFILT-1:0] match;
  always_comb begin
    logic [28:0] fid, mid;
    logic [7:0] ml;
    logic idok;
    fid = '0;
    mid = '0;
    ml = '0;
    idok = 1'b0;
    acc_next = '0;
    for (int f = 0; f < NFILT; f++) begin
      fid = {filt_reg[f][0], filt_reg[f][1][7:5], filt_reg[f][1][1:0],
        filt_reg[f][2], filt_reg[f][3]};
      ml = mask_reg[fptr_reg[f][4]][1];
      mid = {mask_reg[fptr_reg[f][4]][0], ml[7:5], ml[1:0],
        mask_reg[fptr_reg[f][4]][2], mask_reg[fptr_reg[f][4]][3]};
      if (rx_frame.ext) begin
        idok = ((rx_frame.id ^ fid) & mid) == 29'h0;
      end else begin
        idok = ((rx_frame.id[10:0] ^ fid[28:18]) & mid[28:18]) == 11'h000;
      end
      match[f] = idok && (rx_frame.ext == filt_reg[f][1][EXT_BIT])
        && (enhanced || f < NLEGACY);
    end
    for (int f = NFILT - 1; f >= 0; f--) begin
      if (match[f]) begin
        acc_next.hit = 1'b1;
        acc_next.filter = 4'(f);
        acc_next.dest = fptr_reg[f][3:0];
      end
    end
  end

  // Destination buffer index for a configurable target
  logic store;
  logic [2:0] sb;
  assign sb = 3'(acc_next.dest - PTR_FIRST_BUF);
  assign store = rx_valid && acc_next.hit && enhanced
    && acc_next.dest >= PTR_FIRST_BUF && acc_next.dest <= PTR_LAST_BUF
    && !dir_reg[sb];

  // Result reported to the engine for every offered frame
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
    end else if (rx_valid) begin
      acc_reg <= acc_next;
    end
  end
  assign rx_accept = acc_reg;

  // Buffer storage; only payload bytes within the length are loaded
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < NBUF; b++) begin
        len_reg[b] <= 5'h00;
        for (int m = 0; m < NBYTE; m++) begin
          data_reg[b][m] <= RST_BYTE;
        end
      end
    end else begin
      // A frame lands only in a receiver and software writes only a transmitter,
      // so both may happen in one cycle without touching the same buffer
      if (store) begin
        len_reg[sb] <= {rx_frame.rtr, rx_frame.length_code};
        for (int m = 0; m < NBYTE; m++) begin
          if (m < rx_frame.length_code || rx_frame.length_code > DLC_MAX) begin
            data_reg[sb][m] <= rx_frame.data[8*m+:8];
          end
        end
      end
      if (buf_wr && is_len) begin
        len_reg[bn] <= {pwdata[RTR_BIT], pwdata[3:0]};
      end else if (buf_wr) begin
        data_reg[bn][bm[2:0]] <= pwdata[7:0];
      end
    end
  end

  // Direction and mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dir_reg <= RST_DIR;
      mode_reg <= RST_MODE;
    end else if (wr && is_dir) begin
      dir_reg <= pwdata[7:2];
    end else if (wr && is_mode) begin
      mode_reg <= pwdata[1:0];
    end
  end

  // Filters, pointers and masks; low bytes keep only implemented bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int f = 0; f < NFILT; f++) begin
        fptr_reg[f] <= 5'h00;
        for (int k = 0; k < 4; k++) begin
          filt_reg[f][k] <= RST_BYTE;
        end
      end
      for (int n = 0; n < NMASK; n++) begin
        for (int k = 0; k < 4; k++) begin
          mask_reg[n][k] <= RST_BYTE;
        end
      end
    end else if (wr && is_filt && fk == PTR_IDX) begin
      fptr_reg[fn] <= pwdata[4:0];
    end else if (wr && is_filt && fk == 3'h1) begin
      filt_reg[fn][1] <= pwdata[7:0] & SIDL_IMPL;
    end else if (wr && is_filt) begin
      filt_reg[fn][fk[1:0]] <= pwdata[7:0];
    end else if (wr && is_mask && mk == 2'h1) begin
      mask_reg[mn][1] <= pwdata[7:0] & SIDL_IMPL;
    end else if (wr && is_mask) begin
      mask_reg[mn][mk] <= pwdata[7:0];
    end
  end

  // Flattened view for the transmitter
  always_comb begin
    for (int b = 0; b < NBUF; b++) begin
      tx_dir[b] = dir_reg[b];
      tx_rtr[b] = len_reg[b][4];
      tx_dlc[4*b+:4] = len_reg[b][3:0];
      for (int m = 0; m < NBYTE; m++) begin
        tx_data[64*b+8*m+:8] = data_reg[b][m];
      end
    end
  end

  // Checks
  AST_DIR_LOW: assert property (@(posedge mclk) disable iff (rst)
    access && !pwrite && is_dir |-> prdata[1:0] == 2'b00 && prdata[7:2] == dir_reg)
    else $error("direction low bits not zero");
  AST_RX_RO: assert property (@(posedge mclk) disable iff (rst)
    wr && is_buf && !is_len && !dir_reg[bn] && !store
    |=> data_reg[$past(bn)][$past(bm[2:0])] == $past(data_reg[bn][bm[2:0]]))
    else $error("receive byte was written");
  AST_LEN_ZERO: assert property (@(posedge mclk) disable iff (rst)
    access && !pwrite && is_buf && is_len |-> prdata[7] == 1'b0 && prdata[5:4] == 2'b00)
    else $error("length reserved bits not zero");
  AST_RX_RTR: assert property (@(posedge mclk) disable iff (rst)
    store |=> len_reg[$past(sb)] == {$past(rx_frame.rtr), $past(rx_frame.length_code)})
    else $error("received length not stored");
  AST_TX_RTR: assert property (@(posedge mclk) disable iff (rst)
    buf_wr && is_len |=> tx_rtr[$past(bn)] == $past(pwdata[RTR_BIT]))
    else $error("outgoing remote bit not taken");
  AST_LEGACY_ERR: assert property (@(posedge mclk) disable iff (rst)
    setup && !enhanced && paddr[11:9] == 3'h0 && bn < 3'(NBUF) ##1 access |-> pslverr)
    else $error("buffer reachable in legacy mode");
  AST_UPPER_FILT: assert property (@(posedge mclk) disable iff (rst)
    !enhanced |-> match[NFILT-1:NLEGACY] == '0)
    else $error("upper filter matched in legacy mode");
  AST_BUSY_RO: assert property (@(posedge mclk) disable iff (rst)
    wr && is_buf && tx_busy[bn] && !is_len && !store
    |=> data_reg[$past(bn)][$past(bm[2:0])] == $past(data_reg[bn][bm[2:0]]))
    else $error("busy transmit buffer was written");
  AST_TYPE: assert property (@(posedge mclk) disable iff (rst)
    rx_valid && acc_next.hit |-> rx_frame.ext == filt_reg[acc_next.filter][1][EXT_BIT])
    else $error("frame type ignored by filter");
  AST_DEST: assert property (@(posedge mclk) disable iff (rst)
    rx_valid |=> rx_accept.dest == $past(acc_next.dest) && rx_accept.hit == $past(|match))
    else $error("accept result wrong");

  // Software writes land where they should
  AST_TX_WRITE: assert property (@(posedge mclk) disable iff (rst)
    buf_wr && !is_len
    |=> data_reg[$past(bn)][$past(bm[2:0])] == $past(pwdata[7:0]))
    else $error("transmit byte write lost");
  AST_TX_LEN: assert property (@(posedge mclk) disable iff (rst)
    buf_wr && is_len
    |=> len_reg[$past(bn)] == {$past(pwdata[RTR_BIT]), $past(pwdata[3:0])})
    else $error("transmit length write lost");
  AST_DIR_WRITE: assert property (@(posedge mclk) disable iff (rst)
    wr && is_dir
    |=> dir_reg == $past(pwdata[7:2]))
    else $error("direction write lost");
  AST_PTR_WRITE: assert property (@(posedge mclk) disable iff (rst)
    wr && is_filt && fk == PTR_IDX
    |=> fptr_reg[$past(fn)] == $past(pwdata[4:0]))
    else $error("filter pointer write lost");

  // Read-only length registers ignore software
  AST_RX_LEN_RO: assert property (@(posedge mclk) disable iff (rst)
    wr && is_buf && is_len && !dir_reg[bn] && !store
    |=> len_reg[$past(bn)] == $past(len_reg[bn]))
    else $error("receive length was written");
  AST_BUSY_LEN: assert property (@(posedge mclk) disable iff (rst)
    wr && is_buf && is_len && tx_busy[bn] && !store
    |=> len_reg[$past(bn)] == $past(len_reg[bn]))
    else $error("busy transmit length was written");

  // Payload bytes follow the length code of the stored frame
  AST_RX_FIRST: assert property (@(posedge mclk) disable iff (rst)
    store && rx_frame.length_code != 4'h0
    |=> data_reg[$past(sb)][0] == $past(rx_frame.data[7:0]))
    else $error("first payload byte not stored");
  AST_RX_ALL: assert property (@(posedge mclk) disable iff (rst)
    store && rx_frame.length_code >= DLC_MAX
    |=> data_reg[$past(sb)][NBYTE-1] == $past(rx_frame.data[63:56]))
    else $error("last payload byte not stored");
  AST_RX_CUT: assert property (@(posedge mclk) disable iff (rst)
    store && rx_frame.length_code < DLC_MAX
    |=> data_reg[$past(sb)][NBYTE-1] == $past(data_reg[sb][NBYTE-1]))
    else $error("byte beyond the length was stored");

  // Legacy mode hides the upper filters; low bytes keep implemented bits only
  AST_LEGACY_FILT: assert property (@(posedge mclk) disable iff (rst)
    setup && !enhanced && paddr[11:9] == FILT_BASE[11:9] && fn >= 4'(NLEGACY)
    ##1 access |-> pslverr)
    else $error("upper filter reachable in legacy mode");
  AST_FILT_LOW: assert property (@(posedge mclk) disable iff (rst)
    access && !pwrite && is_filt && fk == 3'h1
    |-> (prdata[7:0] & ~SIDL_IMPL) == 8'h00)
    else $error("filter low byte shows unimplemented bits");
  AST_MASK_LOW: assert property (@(posedge mclk) disable iff (rst)
    access && !pwrite && is_mask && mk == 2'h1
    |-> (prdata[7:0] & ~SIDL_IMPL) == 8'h00)
    else $error("mask low byte shows unimplemented bits");

  // Accept result moves only with an offered frame, other outputs only with an accepted frame or a legal write
  AST_ACCEPT_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !rx_valid
    |=> $stable(rx_accept))
    else $error("accept result moved without a frame");
  AST_NO_HIT: assert property (@(posedge mclk) disable iff (rst)
    rx_valid && !acc_next.hit && !buf_wr
    |=> $stable(tx_dlc) && $stable(tx_rtr))
    else $error("unmatched frame was stored");
  AST_LEGACY_DROP: assert property (@(posedge mclk) disable iff (rst)
    wr && !enhanced
    |=> $stable(tx_data) && $stable(tx_dlc))
    else $error("buffer changed in legacy mode");
endmodule

// >>> cbf_engine_model.sv
// Purpose: stand-in for the protocol engine beside the register block
// Assumes: one frame per call, busy flags steered by the bench
// Notes: frame lines show the inverse once no frame is offered
`timescale 1ns/1ps
module cbf_engine_model
  import cbf_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Engine outputs
  output logic rx_valid,
  output cbf_frame_t rx_frame,
  output logic [NBUF-1:0] tx_busy
);
  // Quiet engine at time zero
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_busy = '0;
  end
  // Offer a frame for one cycle, then scramble it so stale data cannot pass
  task automatic send(input cbf_frame_t f);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
  endtask
  // Mark one buffer as pending or sending
  task automatic set_busy(input int n, input logic b);
    @(posedge mclk);
    tx_busy[n] <= b;
  endtask
endmodule

// >>> cbf_regs_bench.sv
// Purpose: register and filter checks over APB
// Assumes: zero-wait slave, byte registers in the low lane
// Notes: every wait is bounded by a count
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %0t value mismatch", $time); end end
module cbf_regs_bench;
  import cbf_pkg::*;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, rx_valid, enhanced;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  cbf_frame_t rx_frame, f;
  cbf_accept_t rx_accept;
  logic [NBUF-1:0] tx_busy, tx_dir, tx_rtr;
  logic [NBUF*4-1:0] tx_dlc;
  logic [NBUF*64-1:0] tx_data;
  int n_fail = 0;
  int n_tests = 0;
  cbf_regs i_cbf_regs (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .rx_accept(rx_accept), .tx_busy(tx_busy), .tx_dir(tx_dir), .tx_rtr(tx_rtr),
    .tx_dlc(tx_dlc), .tx_data(tx_data), .enhanced(enhanced));
  cbf_engine_model i_cbf_engine_model (.mclk(mclk), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .tx_busy(tx_busy));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Verdict and end of run
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One APB transfer; read data and error taken at the pready edge
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] exp, input logic err);
    logic ok;
    logic [31:0] rdat;
    logic serr;
    ok = 1'b0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge mclk);
      ok = (pready === 1'b1);
      rdat = prdata;
      serr = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok) begin
      n_fail++;
      final_report();
    end
    `CHK(serr, err)
    if (!w) `CHK(rdat, {24'h000000, exp})
    #1;
  endtask
  // Bounded run length
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    final_report();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    `CHK(enhanced, 1'b0)
    `CHK(tx_dir, 6'h00)
    acc(0, DIR_ADDR, 0, 8'h00, 0);
    acc(0, BUF_BASE, 0, 8'h00, 1);
    acc(0, FILT_BASE + 12'h0C0, 0, 8'h00, 1);
    // Legacy set-up: software picks the frame type itself
    acc(1, FILT_BASE, 8'h55, 0, 0);
    acc(1, FILT_BASE + 12'h004, 8'hFF, 0, 0);
    acc(0, FILT_BASE + 12'h004, 0, 8'hEB, 0);
    acc(1, FILT_BASE + 12'h004, 8'hE0, 0, 0);
    acc(1, FILT_BASE + 12'h008, 8'h3C, 0, 0);
    acc(0, FILT_BASE + 12'h008, 0, 8'h3C, 0);
    acc(1, MASK_BASE, 8'hFF, 0, 0);
    acc(0, MASK_BASE, 0, 8'hFF, 0);
    acc(1, MASK_BASE + 12'h004, 8'hE0, 0, 0);
    acc(0, MASK_BASE + 12'h004, 0, 8'hE0, 0);
    acc(1, MODE_ADDR, 8'h01, 0, 0);
    `CHK(enhanced, 1'b1)
    acc(1, FILT_BASE + 12'h0C0, 8'h12, 0, 0);
    acc(0, FILT_BASE + 12'h0C0, 0, 8'h12, 0);
    acc(1, FILT_BASE + 12'h010, 8'h03, 0, 0);
    acc(1, DIR_ADDR, 8'hF7, 0, 0);
    acc(0, DIR_ADDR, 0, 8'hF4, 0);
    `CHK(tx_dir, 6'h3D)
    acc(1, BUF_BASE + 12'h00C, 8'hA5, 0, 0);
    acc(0, BUF_BASE + 12'h00C, 0, 8'hA5, 0);
    `CHK(tx_data[31:24], 8'hA5)
    acc(1, BUF_BASE + 12'h020, 8'hFF, 0, 0);
    acc(0, BUF_BASE + 12'h020, 0, 8'h4F, 0);
    `CHK(tx_rtr[0], 1'b1)
    `CHK(tx_dlc[3:0], 4'hF)
    acc(1, BUF_BASE + 12'h020, 8'h08, 0, 0);
    `CHK(tx_rtr[0], 1'b0)
    // Pending send locks the buffer
    i_cbf_engine_model.set_busy(0, 1'b1);
    acc(1, BUF_BASE + 12'h00C, 8'h11, 0, 0);
    acc(0, BUF_BASE + 12'h00C, 0, 8'hA5, 0);
    acc(1, BUF_BASE + 12'h020, 8'h4F, 0, 0);
    acc(0, BUF_BASE + 12'h020, 0, 8'h08, 0);
    i_cbf_engine_model.set_busy(0, 1'b0);
    acc(1, BUF_BASE + 12'h044, 8'h77, 0, 0);
    acc(0, BUF_BASE + 12'h044, 0, 8'h00, 0);
    // Remote frame with an oversized length code into buffer 1
    f = '0;
    f.id = 29'h000002AF;
    f.rtr = 1'b1;
    f.length_code = 4'h9;
    f.data = 64'h8877665544332211;
    i_cbf_engine_model.send(f);
    #1;
    `CHK(rx_accept, 9'h103)
    acc(1, BUF_BASE + 12'h060, 8'h00, 0, 0);
    acc(0, BUF_BASE + 12'h060, 0, 8'h49, 0);
    acc(0, BUF_BASE + 12'h05C, 0, 8'h88, 0);
    f.id = 29'h000002AE;
    i_cbf_engine_model.send(f);
    #1;
    `CHK(rx_accept.hit, 1'b0)
    // Same top identifier bits as filter 0, but an extended frame
    f.id = 29'h0ABC0000;
    f.ext = 1'b1;
    i_cbf_engine_model.send(f);
    #1;
    `CHK(rx_accept.hit, 1'b0)
    // Short data frame: only the first two bytes are replaced
    f.ext = 1'b0;
    f.id = 29'h000002AF;
    f.rtr = 1'b0;
    f.length_code = 4'h2;
    f.data = 64'hEEEEEEEEEEEEBBAA;
    i_cbf_engine_model.send(f);
    #1;
    `CHK(rx_accept, 9'h103)
    acc(0, BUF_BASE + 12'h060, 0, 8'h02, 0);
    acc(0, BUF_BASE + 12'h044, 0, 8'hBB, 0);
    acc(0, BUF_BASE + 12'h05C, 0, 8'h88, 0);
    acc(0, 12'h3FC, 0, 8'h00, 1);
    final_report();
  end
endmodule
